//--- logic/adcs_defs.svh
// timing counts, field positions and codes of the conversion sequencer
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

// conversion length and post-conversion gap, in conversion-clock periods
`define ADCS_CONV_TADS     4'hC
`define ADCS_LAST_TAD      4'hB
`define ADCS_BITS_DONE_TAD 4'hA
`define ADCS_GAP_TADS      4'h2

// successive approximation start code and result layout
`define ADCS_TRIAL_MSB     10'h200
`define ADCS_RES_WIDTH     10
`define ADCS_PAD_ZERO6     6'h00

// clock-select codes
`define ADCS_SEL_DIV2      3'h0
`define ADCS_SEL_DIV8      3'h1
`define ADCS_SEL_DIV32     3'h2
`define ADCS_SEL_RC        3'h3
`define ADCS_SEL_DIV4      3'h4
`define ADCS_SEL_DIV16     3'h5
`define ADCS_SEL_DIV64     3'h6
`define ADCS_SEL_RC_ALT    3'h7

// divider terminal counts (ratio minus one)
`define ADCS_TC_DIV2       6'h01
`define ADCS_TC_DIV4       6'h03
`define ADCS_TC_DIV8       6'h07
`define ADCS_TC_DIV16      6'h0F
`define ADCS_TC_DIV32      6'h1F
`define ADCS_TC_DIV64      6'h3F

`endif

//--- logic/adcs_pkg.sv
// types shared by the conversion sequencer files
package adcs_pkg;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_ACQ,
      ST_CONV,
      ST_GAP
   } adcs_state_t;

   // software configuration, held by the register owner outside
   typedef struct packed {
      logic       result_format;
      logic [2:0] conv_clock_select;
      logic [2:0] channel_select;
      logic       conv_power_on;
   } adcs_cfg_t;

endpackage : adcs_pkg

//--- logic/adcs_sequencer.sv
// successive-approximation conversion sequencer with result and port read logic
// Behaviour
// - result registers keep content through power-on reset
// - two conversion clocks before next acquisition
// - one conversion takes twelve conversion clocks
// - clock-select code picks divider or rc
// - output-direction pin converts its driven level
// - channel and direction never gate conversion
// - port read shows zero on analog pins
// - digital-input pin still converts when selected
// - sampling capacitor disconnected during conversion
// - clearing start bit aborts running conversion
// - abort leaves result registers unchanged
// - after abort, wait two clocks, reacquire
// - completion loads result, clears start, sets flag
// - format bit selects right or left justify
// - reset turns module off, aborts conversion
`include "adcs_defs.svh"

module adcs_sequencer
   import adcs_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // configuration and software strobes
   input  wire adcs_cfg_t  cfg,
   input  wire logic       go_set,
   input  wire logic       go_clear,
   input  wire logic       conv_done_irq_flag_clr,
   input  wire logic       result_wr_high,
   input  wire logic       result_wr_low,
   input  wire logic [7:0] result_wr_data,
   // port pins
   input  wire logic [7:0] pin_analog,
   input  wire logic [7:0] pin_direction,
   input  wire logic [7:0] pin_level,
   // analog side
   input  wire logic       rc_tick,
   input  wire logic       cmp_in,
   // status and results
   output      logic       go_busy,
   output      logic       conv_done_irq_flag,
   output      logic [7:0] result_high,
   output      logic [7:0] result_low,
   output      logic       sample_capacitor_connect,
   output      logic [9:0] trial_code,
   output      logic       convert_driven_level,
   output      logic [7:0] port_read_data
);

   adcs_state_t state;
   adcs_state_t next_state;
   logic [3:0]  tad_cnt;
   logic [3:0]  next_tad_cnt;
   logic [9:0]  bit_mask;
   logic [9:0]  next_bit_mask;
   logic [9:0]  next_trial_code;
   logic        next_go_busy;
   logic        next_connect;
   logic        next_flag;
   logic        done_load;
   logic [7:0]  next_result_high;
   logic [7:0]  next_result_low;
   logic        tad_tick;
   logic        tad_run;

   assign tad_run = ((state == ST_CONV) && !go_clear) || (state == ST_GAP);

   adcs_tad_gen u_tad_gen (
      .sys_clk           (sys_clk),
      .rst               (rst),
      .run               (tad_run),
      .conv_clock_select (cfg.conv_clock_select),
      .rc_tick           (rc_tick),
      .tad_tick          (tad_tick)
   );

   // sequence control
   always_comb begin
      next_state      = state;
      next_tad_cnt    = tad_cnt;
      next_bit_mask   = bit_mask;
      next_trial_code = trial_code;
      next_go_busy    = go_busy;
      next_connect    = sample_capacitor_connect;
      done_load       = 1'b0;
      if (!cfg.conv_power_on) begin
         // shut off: no conversion, capacitor parked
         next_state   = ST_OFF;
         next_go_busy = 1'b0;
         next_connect = 1'b0;
         next_tad_cnt = 4'h0;
      end else begin
         case (state)
            ST_OFF: begin
               // a start in the power-up write finds the module still off
               next_state   = ST_ACQ;
               next_connect = 1'b1;
            end
            ST_ACQ: begin
               // channel and pin direction take no part in the start decision
               if (go_set) begin
                  next_state      = ST_CONV;
                  next_go_busy    = 1'b1;
                  next_connect    = 1'b0;
                  next_tad_cnt    = 4'h0;
                  next_trial_code = `ADCS_TRIAL_MSB;
                  next_bit_mask   = `ADCS_TRIAL_MSB;
               end
            end
            ST_CONV: begin
               if (go_clear) begin
                  // abort: no result load, no flag
                  next_state   = ST_GAP;
                  next_go_busy = 1'b0;
                  next_tad_cnt = 4'h0;
               end else if (tad_tick) begin
                  next_tad_cnt = tad_cnt + 4'h1;
                  if (tad_cnt < `ADCS_BITS_DONE_TAD) begin
                     // keep or drop the trial bit, then try the next lower one
                     next_trial_code = (cmp_in ? trial_code : (trial_code & ~bit_mask)) | (bit_mask >> 1);
                     next_bit_mask   = bit_mask >> 1;
                  end else if (tad_cnt == `ADCS_LAST_TAD) begin
                     next_state   = ST_GAP;
                     next_go_busy = 1'b0;
                     next_tad_cnt = 4'h0;
                     done_load    = 1'b1;
                  end
               end
            end
            ST_GAP: begin
               if (tad_tick) begin
                  next_tad_cnt = tad_cnt + 4'h1;
                  if (tad_cnt == (`ADCS_GAP_TADS - 4'h1)) begin
                     // reacquire on the selected channel unprompted
                     next_state   = ST_ACQ;
                     next_connect = 1'b1;
                     next_tad_cnt = 4'h0;
                  end
               end
            end
            default: begin
               next_state = ST_OFF;
            end
         endcase
      end
   end

   // reset forces the module off and drops any conversion
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state                    <= ST_OFF;
         tad_cnt                  <= 4'h0;
         bit_mask                 <= 10'h000;
         trial_code               <= 10'h000;
         go_busy                  <= 1'b0;
         sample_capacitor_connect <= 1'b0;
      end else begin
         state                    <= next_state;
         tad_cnt                  <= next_tad_cnt;
         bit_mask                 <= next_bit_mask;
         trial_code               <= next_trial_code;
         go_busy                  <= next_go_busy;
         sample_capacitor_connect <= next_connect;
      end
   end

   // completion flag: a completion in the clear cycle still sets it
   always_comb begin
      next_flag = (conv_done_irq_flag & ~conv_done_irq_flag_clr) | done_load;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         conv_done_irq_flag <= 1'b0;
      end else begin
         conv_done_irq_flag <= next_flag;
      end
   end

   // result pair: completion load wins over a software write
   always_comb begin
      next_result_high = result_high;
      next_result_low  = result_low;
      if (done_load && cfg.result_format) begin
         next_result_high = {`ADCS_PAD_ZERO6, trial_code[9:8]};
         next_result_low  = trial_code[7:0];
      end else if (done_load) begin
         next_result_high = trial_code[9:2];
         next_result_low  = {trial_code[1:0], `ADCS_PAD_ZERO6};
      end else begin
         if (result_wr_high) begin
            next_result_high = result_wr_data;
         end
         if (result_wr_low) begin
            next_result_low = result_wr_data;
         end
      end
   end

   // no reset term: content survives reset untouched
   always_ff @(posedge sys_clk) begin
      result_high <= next_result_high;
      result_low  <= next_result_low;
   end

   // port readback and conversion source of the selected pin
   logic [7:0] next_port_read;
   logic       next_driven;

   always_comb begin
      next_port_read = pin_level & ~pin_analog;
      // an output pin feeds its own drive level; a digital input still converts
      next_driven    = ~pin_direction[cfg.channel_select];
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         port_read_data       <= 8'h00;
         convert_driven_level <= 1'b0;
      end else begin
         port_read_data       <= next_port_read;
         convert_driven_level <= next_driven;
      end
   end

   // checking helpers: conversion clocks seen per conversion and per gap
   logic [3:0] chk_conv_tads;
   logic [3:0] chk_gap_tads;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         chk_conv_tads <= 4'h0;
         chk_gap_tads  <= 4'h0;
      end else begin
         if (state == ST_ACQ) begin
            chk_conv_tads <= 4'h0;
         end else if ((state == ST_CONV) && tad_tick) begin
            chk_conv_tads <= chk_conv_tads + 4'h1;
         end
         if (state != ST_GAP) begin
            chk_gap_tads <= 4'h0;
         end else if (tad_tick) begin
            chk_gap_tads <= chk_gap_tads + 4'h1;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_conv_twelve;
      $rose(conv_done_irq_flag) |-> (chk_conv_tads == `ADCS_CONV_TADS);
   endproperty
   a_conv_twelve: assert property (p_conv_twelve) else $error("conversion not twelve clocks");

   property p_gap_two;
      (state == ST_ACQ) && ($past(state) == ST_GAP) |-> (chk_gap_tads == `ADCS_GAP_TADS) && sample_capacitor_connect;
   endproperty
   a_gap_two: assert property (p_gap_two) else $error("reacquire without two clock gap");

   property p_disconnect;
      (state == ST_CONV) |-> !sample_capacitor_connect;
   endproperty
   a_disconnect: assert property (p_disconnect) else $error("capacitor connected in conversion");

   property p_abort;
      (state == ST_CONV) && go_clear && cfg.conv_power_on && !result_wr_high && !result_wr_low
         |=> !go_busy && (state == ST_GAP) && $stable(result_high) && $stable(result_low)
             && ($rose(conv_done_irq_flag) == 1'b0);
   endproperty
   a_abort: assert property (p_abort) else $error("abort changed result or flag");

   property p_done;
      $rose(conv_done_irq_flag) |-> $fell(go_busy) && (state == ST_GAP);
   endproperty
   a_done: assert property (p_done) else $error("flag without completion");

   property p_right_just;
      $rose(conv_done_irq_flag) && $past(cfg.result_format) |-> (result_high[7:2] == 6'h00)
         && ({result_high[1:0], result_low} == $past(trial_code));
   endproperty
   a_right_just: assert property (p_right_just) else $error("right justified layout wrong");

   property p_left_just;
      $rose(conv_done_irq_flag) && !$past(cfg.result_format) |-> (result_low[5:0] == 6'h00)
         && ({result_high, result_low[7:6]} == $past(trial_code));
   endproperty
   a_left_just: assert property (p_left_just) else $error("left justified layout wrong");

   property p_powered;
      !cfg.conv_power_on |=> !go_busy && (state == ST_OFF);
   endproperty
   a_powered: assert property (p_powered) else $error("busy while unpowered");

   property p_start;
      (state == ST_ACQ) && go_set && cfg.conv_power_on |=> go_busy ##0 (trial_code == `ADCS_TRIAL_MSB);
   endproperty
   a_start: assert property (p_start) else $error("start refused or not msb first");

   property p_powerup_start;
      $rose(cfg.conv_power_on) && go_set |=> !go_busy;
   endproperty
   a_powerup_start: assert property (p_powerup_start) else $error("started in power-up write");

   property p_port_read;
      1'b1 |=> ((port_read_data & $past(pin_analog)) == 8'h00);
   endproperty
   a_port_read: assert property (p_port_read) else $error("analog pin read nonzero");

   property p_driven;
      1'b1 |=> (convert_driven_level == !$past(pin_direction[cfg.channel_select]));
   endproperty
   a_driven: assert property (p_driven) else $error("driven level source wrong");

   c_done:  cover property ($rose(conv_done_irq_flag));
   c_abort: cover property ((state == ST_CONV) && go_clear ##1 (state == ST_GAP));
   c_right: cover property ($rose(conv_done_irq_flag) && cfg.result_format);
   c_reacq: cover property ((state == ST_GAP) ##1 (state == ST_ACQ));

endmodule : adcs_sequencer

//--- logic/adcs_tad_gen.sv
// conversion clock tick generator: oscillator divider or internal rc tick
`include "adcs_defs.svh"

module adcs_tad_gen
   import adcs_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // control
   input  wire logic       run,
   input  wire logic [2:0] conv_clock_select,
   input  wire logic       rc_tick,
   // tick out
   output      logic       tad_tick
);

   logic [5:0] div_cnt;
   logic [5:0] next_div_cnt;
   logic       next_tad_tick;
   logic [5:0] term;
   logic       use_rc;

   always_comb begin
      term   = `ADCS_TC_DIV2;
      use_rc = 1'b0;
      case (conv_clock_select)
         `ADCS_SEL_DIV2:   term = `ADCS_TC_DIV2;
         `ADCS_SEL_DIV4:   term = `ADCS_TC_DIV4;
         `ADCS_SEL_DIV8:   term = `ADCS_TC_DIV8;
         `ADCS_SEL_DIV16:  term = `ADCS_TC_DIV16;
         `ADCS_SEL_DIV32:  term = `ADCS_TC_DIV32;
         `ADCS_SEL_DIV64:  term = `ADCS_TC_DIV64;
         default:          use_rc = 1'b1;
      endcase
   end

   // divide the oscillator at the selected ratio
   always_comb begin
      next_div_cnt  = 6'h00;
      next_tad_tick = 1'b0;
      if (run && use_rc) begin
         next_tad_tick = rc_tick;
      end else if (run && (div_cnt >= term)) begin
         next_tad_tick = 1'b1;
      end else if (run) begin
         next_div_cnt = div_cnt + 6'h01;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_cnt  <= 6'h00;
         tad_tick <= 1'b0;
      end else begin
         div_cnt  <= next_div_cnt;
         tad_tick <= next_tad_tick;
      end
   end

endmodule : adcs_tad_gen

//--- verification/adcs_tb_top.sv
// self-checking bench of the conversion sequencer
module adc_conversion_sequencer_tb_top
   import adcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic       sys_clk = 1'b0;
   logic       rst;
   adcs_cfg_t  cfg;
   logic       go_set;
   logic       go_clear;
   logic       flag_clr;
   logic       wr_high;
   logic       wr_low;
   logic [7:0] wr_data;
   logic [7:0] pin_analog;
   logic [7:0] pin_direction;
   logic [7:0] pin_level;
   logic       rc_tick;
   logic [1:0] rc_cnt;
   logic       cmp_in;
   logic       go_busy;
   logic       flag;
   logic [7:0] result_high;
   logic [7:0] result_low;
   logic       connect;
   logic [9:0] trial_code;
   logic       drv_level;
   logic [7:0] port_read;
   logic [9:0] target;
   int         num_errors;
   int         checks;

   adcs_sequencer u_dut (
      .sys_clk(sys_clk), .rst(rst), .cfg(cfg), .go_set(go_set), .go_clear(go_clear),
      .conv_done_irq_flag_clr(flag_clr), .result_wr_high(wr_high), .result_wr_low(wr_low),
      .result_wr_data(wr_data), .pin_analog(pin_analog), .pin_direction(pin_direction),
      .pin_level(pin_level), .rc_tick(rc_tick), .cmp_in(cmp_in), .go_busy(go_busy),
      .conv_done_irq_flag(flag), .result_high(result_high), .result_low(result_low),
      .sample_capacitor_connect(connect), .trial_code(trial_code),
      .convert_driven_level(drv_level), .port_read_data(port_read));

   // comparator: the sampled input is at or above the trial code
   assign cmp_in = (target >= trial_code);

   always #12.5 sys_clk = ~sys_clk;

   // internal rc clock stand-in: one tick every four cycles
   always @(posedge sys_clk) begin
      if (rst) begin
         rc_cnt  <= 2'h0;
         rc_tick <= 1'b0;
      end else begin
         rc_cnt  <= rc_cnt + 2'h1;
         rc_tick <= (rc_cnt == 2'h3);
      end
   end

   task automatic tick();
      @(posedge sys_clk);
      #2;
   endtask : tick

   task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   task automatic pulse(ref logic s);
      s = 1'b1;
      tick();
      s = 1'b0;
   endtask : pulse

   // wait for acquisition; returns cycles waited
   task automatic wait_acq(output int n);
      n = 0;
      while (connect !== 1'b1 && n < 300) begin
         tick();
         n++;
      end
      check("acquiring", 10'h001, {9'h000, connect});
   endtask : wait_acq

   function automatic int ratio_of(input logic [2:0] sel);
      case (sel)
         3'h0: return 2;
         3'h4: return 4;
         3'h1: return 8;
         3'h5: return 16;
         3'h2: return 32;
         3'h6: return 64;
         default: return 4;
      endcase
   endfunction : ratio_of

   task automatic start();
      pulse(go_set);
      check("busy after start", 10'h001, {9'h000, go_busy});
      check("capacitor off", 10'h000, {9'h000, connect});
      check("first trial", 10'h200, trial_code);
   endtask : start

   task automatic convert(input logic [2:0] sel, input logic fmt, input logic [9:0] val);
      int n;
      int r;
      r = ratio_of(sel);
      cfg.conv_clock_select = sel;
      cfg.result_format = fmt;
      target = val;
      wait_acq(n);
      pulse(flag_clr);
      check("flag cleared", 10'h000, {9'h000, flag});
      start();
      n = 0;
      while (go_busy === 1'b1 && n < 1000) begin
         tick();
         n++;
      end
      if (n < 12 * r - 4 || n > 12 * r + 4) begin
         num_errors++;
         $display("mismatch busy length expected %0d seen %0d", 12 * r, n);
      end
      checks++;
      check("done flag", 10'h001, {9'h000, flag});
      if (fmt) check("right result", val, {result_high[1:0], result_low});
      else check("left result", val, {result_high, result_low[7:6]});
      check("pad bits", 10'h000, fmt ? {4'h0, result_high[7:2]} : {4'h0, result_low[5:0]});
      if (r >= 8) begin
         pulse(go_set);
         tick();
         check("start in gap", 10'h000, {9'h000, go_busy});
      end
      wait_acq(n);
      if (n < 2 * r - 4 || n > 2 * r + 6) begin
         num_errors++;
         $display("mismatch gap length expected %0d seen %0d", 2 * r, n);
      end
   endtask : convert

   task automatic abort_case();
      int n;
      cfg.conv_clock_select = 3'h1;
      wr_data = 8'hA5;
      pulse(wr_high);
      wr_data = 8'h3C;
      pulse(wr_low);
      pulse(flag_clr);
      check("written result", 10'h0A5, {2'h0, result_high});
      wait_acq(n);
      start();
      // abort between two conversion clocks, so a shortened gap would show
      repeat (43) tick();
      pulse(go_clear);
      check("abort busy", 10'h000, {9'h000, go_busy});
      check("abort flag", 10'h000, {9'h000, flag});
      check("abort result", 10'h0A5, {2'h0, result_high});
      check("abort result low", 10'h03C, {2'h0, result_low});
      check("abort capacitor", 10'h000, {9'h000, connect});
      wait_acq(n);
      if (n < 16 || n > 18) begin
         num_errors++;
         $display("mismatch reacquire wait expected %0d seen %0d", 17, n);
      end
   endtask : abort_case

   task automatic power_case();
      int n;
      cfg.conv_clock_select = 3'h6;
      start();
      repeat (5) tick();
      cfg.conv_power_on = 1'b0;
      tick();
      tick();
      check("off busy", 10'h000, {9'h000, go_busy});
      check("off capacitor", 10'h000, {9'h000, connect});
      pulse(go_set);
      tick();
      check("start while off", 10'h000, {9'h000, go_busy});
      cfg.conv_power_on = 1'b1;
      pulse(go_set);
      check("start in power-up write", 10'h000, {9'h000, go_busy});
      tick();
      wait_acq(n);
      start();
      repeat (5) tick();
      rst = 1'b1;
      #3;
      check("reset busy", 10'h000, {9'h000, go_busy});
      check("reset keeps result", 10'h0A5, {2'h0, result_high});
      tick();
      rst = 1'b0;
      tick();
      tick();
      check("reacquire after reset", 10'h001, {9'h000, connect});
   endtask : power_case

   initial begin
      #200us;
      num_errors++;
      give_verdict();
   end

   initial begin
      logic [9:0] vals [8];
      vals = '{10'h3FF, 10'h000, 10'h2A5, 10'h15A, 10'h200, 10'h1FF, 10'h001, 10'h3FE};
      rst = 1'b1;
      cfg = '{result_format: 1'b1, conv_clock_select: 3'h0, channel_select: 3'h2, conv_power_on: 1'b1};
      {go_set, go_clear, flag_clr, wr_high, wr_low} = 5'h00;
      wr_data = 8'h00;
      {pin_analog, pin_direction, pin_level} = {8'hF4, 8'hFF, 8'hFF};
      target = 10'h000;
      num_errors = 0;
      checks = 0;
      tick();
      tick();
      check("reset busy", 10'h000, {9'h000, go_busy});
      check("reset flag", 10'h000, {9'h000, flag});
      rst = 1'b0;
      tick();
      tick();
      check("powered acquire", 10'h001, {9'h000, connect});
      check("port read", 10'h00B, {2'h0, port_read});
      pin_direction = 8'hFB;
      tick();
      tick();
      check("driven level", 10'h001, {9'h000, drv_level});
      pin_direction = 8'hFF;
      tick();
      tick();
      check("input level", 10'h000, {9'h000, drv_level});
      pin_direction = 8'h00;
      for (int i = 0; i < 8; i++) begin
         cfg.channel_select = i[2:0];
         convert(i[2:0], i[0], vals[i]);
      end
      pin_direction = 8'hFF;
      abort_case();
      power_case();
      give_verdict();
   end
endmodule : adc_conversion_sequencer_tb_top
